// File: bench/pmwc_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module pmwc_far_side #(parameter int HSRC_DLY = 6) (
    // clock and block power state
    input  wire logic core_clk_i,
    input  wire logic hsrc_on_i,
    input  wire logic osc_on_i,
    // oscillator and monitor status
    output logic      osc32k_o,
    output logic      supply_voltage_monitor_ok_o,
    output logic      hsrc_stable_o
);
    int warm = 0;
    initial {osc32k_o, hsrc_stable_o} = 2'h0;
    assign supply_voltage_monitor_ok_o = 1'b1;
    // no swing while unpowered, so a missing restart shows up
    always #15625 osc32k_o = osc_on_i & ~osc32k_o;
    // fast rc never reports stable while unpowered
    always @(posedge core_clk_i) begin
        warm <= hsrc_on_i ? warm + 1 : 0;
        hsrc_stable_o <= hsrc_on_i && warm >= HSRC_DLY;
    end
endmodule : pmwc_far_side
`default_nettype wire

// File: bench/pmwc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pmwc_top_tb;
    import pmwc_pkg::*;
    logic            core_clk_i = 1'b0, resetn_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, ext_reset_n_i = 1'b1;
    logic            comp_out_i = 1'b0, irq_i = 1'b0, radio_req_i = 1'b0;
    logic [1:0]      htrans_i = 2'h0, pulse_in_i = 2'h0;
    logic [31:0]     haddr_i = '0, hwdata_i = '0, st;
    logic [NPIN-1:0] digital_io_pin_i = '0, core_pin_out_i = '0;
    wire logic [31:0]     hrdata_o;
    wire logic            hreadyout_o, hresp_o, cpu_halt_o, cpu_reset_n_o;
    wire logic            osc32k_i, supply_voltage_monitor_ok_i, hsrc_stable_i;
    wire logic [NPIN-1:0] pin_out_o, pin_oe_o, pin_pullup_o;
    wire pmwc_pwr_t       pwr_o;
    int              miscompares = 0, samples_checked = 0, cycles = 0, t0;
    always #50 core_clk_i = ~core_clk_i;
    pmwc_top pmwc_top_inst (.core_clk_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
        .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .digital_io_pin_i, .ext_reset_n_i,
        .comp_out_i, .osc32k_i, .pulse_in_i, .supply_voltage_monitor_ok_i, .hsrc_stable_i,
        .brownout_reset_i(1'b0), .core_pin_out_i, .core_pin_oe_i(core_pin_out_i), .core_pullup_i(core_pin_out_i),
        .irq_i, .radio_req_i, .pin_out_o, .pin_oe_o, .pin_pullup_o, .pwr_o, .cpu_halt_o, .cpu_reset_n_o);
    pmwc_far_side pmwc_far_side_inst (.core_clk_i, .hsrc_on_i(pwr_o.hsrc), .osc_on_i(pwr_o.osc32k),
        .osc32k_o(osc32k_i), .supply_voltage_monitor_ok_o(supply_voltage_monitor_ok_i), .hsrc_stable_o(hsrc_stable_i));
    task automatic tally_and_finish;
        $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // read data lands in st at the data-phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        hsel_i   <= 1'b1;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        haddr_i  <= {24'h0, a};
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        st = hrdata_o;
    endtask : bus
    task automatic wait_rst(input logic lvl);
        while (cpu_reset_n_o !== lvl) @(posedge core_clk_i);
    endtask : wait_rst
    task automatic clr;
        bus(1'b1, OFF_PIN_PEND, '1);
        bus(1'b1, OFF_SRC_PEND, '1);
    endtask : clr
    task automatic t_powerup;
        repeat (8) @(posedge core_clk_i);
        chk(32'(pwr_o), 32'h08);
        resetn_i <= 1'b1;
        wait_rst(1'b1);
        chk({pwr_o.digital, pwr_o.ram, pwr_o.radio, pwr_o.aon}, 4'hd);
        bus(1'b0, OFF_STATUS, '0);
        chk(st[5:4], CAUSE_POWERUP);
        bus(1'b0, 8'hfc, '0);
        chk(st, '0);
    endtask : t_powerup
    task automatic t_doze;
        radio_req_i <= 1'b1;
        bus(1'b1, OFF_CTRL, 32'h1 << CTRL_DOZE);
        repeat (3) @(posedge core_clk_i);
        chk({cpu_halt_o, pwr_o.radio}, 2'h3);
        irq_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        irq_i <= 1'b0;
        chk(cpu_halt_o, 1'b0);
    endtask : t_doze
    task automatic t_sleep;
        core_pin_out_i <= 20'h5;
        bus(1'b1, OFF_PIN_EN, 32'h3);
        bus(1'b1, OFF_PIN_EDGE, 32'h1);
        clr();
        bus(1'b1, OFF_CTRL, 32'h1 << CTRL_SLEEP | 32'h1 << CTRL_RAM_RET);
        wait_rst(1'b0);
        repeat (2) @(posedge core_clk_i);
        chk({pwr_o.digital, pwr_o.ram, pwr_o.radio, pwr_o.aon, pwr_o.osc32k}, 5'h0a);
        core_pin_out_i <= 20'hfffff;
        repeat (3) @(posedge core_clk_i);
        chk(pin_out_o, 20'h5);
        chk(pin_oe_o, 20'h5);
        chk(pin_pullup_o, 20'h5);
        digital_io_pin_i <= 20'h1;
        wait_rst(1'b1);
        bus(1'b0, OFF_STATUS, '0);
        chk(st[ST_OSC_BIT:4], {1'b1, CAUSE_WAKE});
        chk(pin_out_o, 20'hfffff);
    endtask : t_sleep
    task automatic t_deep;
        clr();
        bus(1'b1, OFF_CTRL, 32'h1 << CTRL_DEEP);
        wait_rst(1'b0);
        repeat (2) @(posedge core_clk_i);
        chk(32'(pwr_o), 32'h08);
        digital_io_pin_i <= 20'h3;
        repeat (20) @(posedge core_clk_i);
        chk(cpu_reset_n_o, 1'b0);
        digital_io_pin_i <= 20'h1;
        wait_rst(1'b1);
        bus(1'b0, OFF_PIN_EN, '0);
        chk(st, '0);
    endtask : t_deep
    task automatic t_rewake;
        bus(1'b1, OFF_SRC_EN, 32'h1 << SRC_CMP);
        comp_out_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        bus(1'b1, OFF_CTRL, 32'h1 << CTRL_SLEEP);
        t0 = cycles;
        wait_rst(1'b0);
        wait_rst(1'b1);
        chk(cycles - t0 < 60, 1'b1);
    endtask : t_rewake
    task automatic t_pulse;
        bus(1'b1, OFF_PC_CMP, 32'h00020003);
        bus(1'b1, OFF_SRC_EN, 32'h1 << SRC_PC0);
        clr();
        bus(1'b1, OFF_CTRL, 32'h1 << CTRL_SLEEP);
        wait_rst(1'b0);
        repeat (4) begin
            pulse_in_i <= 2'h3;
            repeat (2) @(posedge core_clk_i);
            pulse_in_i <= 2'h0;
            repeat (2) @(posedge core_clk_i);
        end
        wait_rst(1'b1);
        bus(1'b0, OFF_PC_CNT, '0);
        chk(st, 32'h00040004);
        bus(1'b0, OFF_SRC_PEND, '0);
        chk(st, 32'h0c);
    endtask : t_pulse
    task automatic t_timer;
        clr();
        bus(1'b0, OFF_T0_CNT_LO, '0);
        bus(1'b1, OFF_T0_CMP_LO, st + 32'h2);
        repeat (700) @(posedge core_clk_i);
        bus(1'b0, OFF_SRC_PEND, '0);
        chk(st, 32'h1 << SRC_T0);
    endtask : t_timer
    task automatic t_extrst;
        clr();
        bus(1'b1, OFF_CTRL, 32'h1 << CTRL_DEEP);
        wait_rst(1'b0);
        ext_reset_n_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        ext_reset_n_i <= 1'b1;
        wait_rst(1'b1);
        bus(1'b0, OFF_STATUS, '0);
        chk(st[5:4], CAUSE_EXTRST);
    endtask : t_extrst
    initial begin
        t_powerup();
        t_doze();
        t_sleep();
        t_deep();
        t_rewake();
        t_pulse();
        t_timer();
        t_extrst();
        tally_and_finish();
    end
endmodule : pmwc_top_tb
`default_nettype wire

// File: rtl/pmwc_pkg.sv
`default_nettype none
package pmwc_pkg;
    localparam int NPIN  = 20;
    localparam int TMR_W = 41;
    localparam int PC_W  = 16;
    localparam int NSRC  = 5;

    localparam int CLK_PERIOD_NS  = 100;
    localparam int PWR_SETTLE_NS  = 1000;
    localparam int PWR_SETTLE_CYC = (PWR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W       = 8;

    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_STATUS    = 8'h04;
    localparam logic [7:0] OFF_PIN_EN    = 8'h08;
    localparam logic [7:0] OFF_PIN_EDGE  = 8'h0c;
    localparam logic [7:0] OFF_PIN_PEND  = 8'h10;
    localparam logic [7:0] OFF_SRC_EN    = 8'h14;
    localparam logic [7:0] OFF_SRC_PEND  = 8'h18;
    localparam logic [7:0] OFF_T0_CMP_LO = 8'h1c;
    localparam logic [7:0] OFF_T0_CMP_HI = 8'h20;
    localparam logic [7:0] OFF_T1_CMP_LO = 8'h24;
    localparam logic [7:0] OFF_T1_CMP_HI = 8'h28;
    localparam logic [7:0] OFF_PC_CMP    = 8'h2c;
    localparam logic [7:0] OFF_PC_CNT    = 8'h30;
    localparam logic [7:0] OFF_T0_CNT_LO = 8'h34;

    localparam int CTRL_DOZE     = 0;
    localparam int CTRL_SLEEP    = 1;
    localparam int CTRL_DEEP     = 2;
    localparam int CTRL_RAM_RET  = 3;
    localparam int CTRL_TMR_KEEP = 4;
    localparam int CTRL_OSC_KEEP = 5;
    localparam int CTRL_DEBOUNCE = 6;

    localparam int SRC_T0  = 0;
    localparam int SRC_PC0 = 2;
    localparam int SRC_CMP = 4;

    localparam int ST_MODE_LSB  = 0;
    localparam int ST_CAUSE_LSB = 4;
    localparam int ST_OSC_BIT   = 6;

    localparam logic [1:0] CAUSE_POWERUP = 2'h0;
    localparam logic [1:0] CAUSE_EXTRST  = 2'h1;
    localparam logic [1:0] CAUSE_WAKE    = 2'h2;

    localparam logic [NPIN-1:0] PIN_RST = '0;
    localparam logic [NSRC-1:0] SRC_RST = '0;

    typedef enum logic [2:0] {
        ST_ACTIVE, ST_DOZE, ST_SLEEP, ST_DEEP, ST_CHK_SUPPLY, ST_HSRC, ST_PWR_ON, ST_RELEASE
    } pmwc_state_t;

    typedef struct packed {
        logic digital;
        logic ram;
        logic radio;
        logic aon;
        logic timers;
        logic osc32k;
        logic hsrc;
    } pmwc_pwr_t;

    typedef struct packed {
        logic debounce;
        logic osc_keep;
        logic tmr_keep;
        logic ram_ret;
    } pmwc_cfg_t;
endpackage : pmwc_pkg
`default_nettype wire

// File: rtl/pmwc_top.sv
`timescale 1ns/1ps
`default_nettype none
module pmwc_top (
    // clock and reset
    input  wire logic                      core_clk_i,
    input  wire logic                      resetn_i,
    // ahb-lite slave
    input  wire logic                      hsel_i,
    input  wire logic [31:0]               haddr_i,
    input  wire logic [1:0]                htrans_i,
    input  wire logic                      hwrite_i,
    input  wire logic [2:0]                hsize_i,
    input  wire logic [31:0]               hwdata_i,
    input  wire logic                      hready_i,
    output logic      [31:0]               hrdata_o,
    output logic                           hreadyout_o,
    output logic                           hresp_o,
    // asynchronous pins and analog status
    input  wire logic [pmwc_pkg::NPIN-1:0] digital_io_pin_i,
    input  wire logic                      ext_reset_n_i,
    input  wire logic                      comp_out_i,
    input  wire logic                      osc32k_i,
    input  wire logic [1:0]                pulse_in_i,
    input  wire logic                      supply_voltage_monitor_ok_i,
    input  wire logic                      hsrc_stable_i,
    input  wire logic                      brownout_reset_i,
    // core side
    input  wire logic [pmwc_pkg::NPIN-1:0] core_pin_out_i,
    input  wire logic [pmwc_pkg::NPIN-1:0] core_pin_oe_i,
    input  wire logic [pmwc_pkg::NPIN-1:0] core_pullup_i,
    input  wire logic                      irq_i,
    input  wire logic                      radio_req_i,
    // pin cells, power and cpu control
    output logic      [pmwc_pkg::NPIN-1:0] pin_out_o,
    output logic      [pmwc_pkg::NPIN-1:0] pin_oe_o,
    output logic      [pmwc_pkg::NPIN-1:0] pin_pullup_o,
    output pmwc_pkg::pmwc_pwr_t            pwr_o,
    output logic                           cpu_halt_o,
    output logic                           cpu_reset_n_o
);
    import pmwc_pkg::*;

    localparam int NSYNC = NPIN + 8;

    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [NPIN-1:0]  pin_s, pin_p;
    logic [1:0]       pulse_s, pulse_p;
    logic             ext_s, comp_s, comp_p, osc_s, osc_p, sup_s, hsrc_s, bor_s;

    // inverter ahead of the first stage keeps reset-to-zero meaning "pin idle"
    assign async_in = {pulse_in_i, brownout_reset_i, hsrc_stable_i, supply_voltage_monitor_ok_i,
                       osc32k_i, comp_out_i, ~ext_reset_n_i, digital_io_pin_i};

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= async_in;
            sync2 <= sync1;
        end
    end

    assign pin_s   = sync2[NPIN-1:0];
    assign ext_s   = sync2[NPIN];
    assign comp_s  = sync2[NPIN+1];
    assign osc_s   = sync2[NPIN+2];
    assign sup_s   = sync2[NPIN+3];
    assign hsrc_s  = sync2[NPIN+4];
    assign bor_s   = sync2[NPIN+5];
    assign pulse_s = sync2[NPIN+7:NPIN+6];

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            pin_p   <= '0;
            comp_p  <= 1'b0;
            osc_p   <= 1'b0;
            pulse_p <= '0;
        end else begin
            pin_p   <= pin_s;
            comp_p  <= comp_s;
            osc_p   <= osc_s;
            pulse_p <= pulse_s;
        end
    end

    pmwc_state_t state, next_state;
    pmwc_cfg_t   cfg;
    logic        hard, soft_clr, cfg_rst_n, tick32, any_wake, deep_wake;
    logic [1:0]  cause;
    logic [SETTLE_W-1:0] settle_cnt;

    assign hard      = ext_s | bor_s;
    assign cfg_rst_n = resetn_i & ~soft_clr;
    assign tick32    = osc_s & ~osc_p & pwr_o.osc32k;

    // bus slave: zero wait states, always OKAY
    logic        acc, wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rd_mux;

    assign acc = hsel_i & htrans_i[1] & hready_i;

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= acc & hwrite_i & (haddr_i[31:8] == 24'h000000);
            if (acc) begin
                wr_addr <= haddr_i[7:0];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            hrdata_o    <= 32'h0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            hrdata_o    <= (acc && !hwrite_i && haddr_i[31:8] == 24'h000000) ? rd_mux : 32'h0;
        end
    end

    logic wr_ctrl, doze_req, sleep_req, deep_req;
    assign wr_ctrl   = wr_pend && wr_addr == OFF_CTRL;
    assign doze_req  = wr_ctrl & hwdata_i[CTRL_DOZE];
    assign sleep_req = wr_ctrl & hwdata_i[CTRL_SLEEP];
    assign deep_req  = wr_ctrl & hwdata_i[CTRL_DEEP];

    logic [NPIN-1:0]  pin_en, pin_edge, pin_pend, pin_hit;
    logic [NSRC-1:0]  src_en, src_pend, src_set;
    logic [TMR_W-1:0] t_cmp [2];
    logic [TMR_W-1:0] t_cnt [2];
    logic [PC_W-1:0]  pc_cmp [2];
    logic [PC_W-1:0]  pc_cnt [2];

    // configuration is lost on deep exit or hard reset
    always_ff @(posedge core_clk_i) begin
        if (!cfg_rst_n) begin
            cfg      <= '0;
            pin_en   <= PIN_RST;
            pin_edge <= PIN_RST;
            src_en   <= SRC_RST;
        end else if (wr_pend) begin
            unique case (wr_addr)
                OFF_CTRL: begin
                    cfg.ram_ret  <= hwdata_i[CTRL_RAM_RET];
                    cfg.tmr_keep <= hwdata_i[CTRL_TMR_KEEP];
                    cfg.osc_keep <= hwdata_i[CTRL_OSC_KEEP];
                    cfg.debounce <= hwdata_i[CTRL_DEBOUNCE];
                end
                OFF_PIN_EN:   pin_en   <= hwdata_i[NPIN-1:0];
                OFF_PIN_EDGE: pin_edge <= hwdata_i[NPIN-1:0];
                OFF_SRC_EN:   src_en   <= hwdata_i[NSRC-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!cfg_rst_n) begin
            t_cmp[0]  <= '0;
            t_cmp[1]  <= '0;
            pc_cmp[0] <= '0;
            pc_cmp[1] <= '0;
        end else if (wr_pend) begin
            unique case (wr_addr)
                OFF_T0_CMP_LO: t_cmp[0][31:0]      <= hwdata_i;
                OFF_T0_CMP_HI: t_cmp[0][TMR_W-1:32] <= hwdata_i[TMR_W-33:0];
                OFF_T1_CMP_LO: t_cmp[1][31:0]      <= hwdata_i;
                OFF_T1_CMP_HI: t_cmp[1][TMR_W-1:32] <= hwdata_i[TMR_W-33:0];
                OFF_PC_CMP: begin
                    pc_cmp[0] <= hwdata_i[PC_W-1:0];
                    pc_cmp[1] <= hwdata_i[2*PC_W-1:PC_W];
                end
                default: ;
            endcase
        end
    end

    // pins watched at the input cell, whatever function owns them
    assign pin_hit = pin_en & ((pin_edge & pin_s & ~pin_p) | (~pin_edge & ~pin_s & pin_p));

    // set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge core_clk_i) begin
        if (!cfg_rst_n) begin
            pin_pend <= PIN_RST;
            src_pend <= SRC_RST;
        end else begin
            pin_pend <= (pin_pend & ~((wr_pend && wr_addr == OFF_PIN_PEND) ? hwdata_i[NPIN-1:0] : PIN_RST))
                        | pin_hit;
            src_pend <= (src_pend & ~((wr_pend && wr_addr == OFF_SRC_PEND) ? hwdata_i[NSRC-1:0] : SRC_RST))
                        | src_set;
        end
    end

    logic [1:0] pc_edge, pc_db;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            pmwc_wake_timer u_timer (
                .core_clk_i (core_clk_i),
                .resetn_i   (cfg_rst_n),
                .tick_i     (tick32 & pwr_o.timers),
                .cmp_i      (t_cmp[gi]),
                .cnt_o      (t_cnt[gi]),
                .event_o    (src_set[SRC_T0+gi])
            );

            // debounced edges need the 32 kHz tick; raw edges do not
            assign pc_edge[gi] = cfg.debounce ? (tick32 & pulse_s[gi] & ~pc_db[gi])
                                              : (pulse_s[gi] & ~pulse_p[gi]);

            always_ff @(posedge core_clk_i) begin
                if (!cfg_rst_n) begin
                    pc_db[gi]  <= 1'b0;
                    pc_cnt[gi] <= '0;
                end else begin
                    if (tick32) begin
                        pc_db[gi] <= pulse_s[gi];
                    end
                    if (pc_edge[gi] && state != ST_DEEP) begin
                        pc_cnt[gi] <= pc_cnt[gi] + PC_W'(1);
                    end
                end
            end

            assign src_set[SRC_PC0+gi] = pc_edge[gi] && state != ST_DEEP
                                         && (pc_cnt[gi] + PC_W'(1) == pc_cmp[gi]);
        end
    endgenerate

    assign src_set[SRC_CMP] = comp_s ^ comp_p;

    assign any_wake  = (|pin_pend) | (|(src_pend & src_en));
    assign deep_wake = (|pin_pend) | (src_pend[SRC_CMP] & src_en[SRC_CMP]);

    always_comb begin
        rd_mux = 32'h0;
        unique case (haddr_i[7:0])
            OFF_CTRL:      rd_mux[CTRL_DEBOUNCE:CTRL_RAM_RET] = {cfg.debounce, cfg.osc_keep, cfg.tmr_keep, cfg.ram_ret};
            OFF_STATUS: begin
                rd_mux[ST_MODE_LSB+:3]  = state;
                rd_mux[ST_CAUSE_LSB+:2] = cause;
                rd_mux[ST_OSC_BIT]      = pwr_o.osc32k;
            end
            OFF_PIN_EN:    rd_mux[NPIN-1:0] = pin_en;
            OFF_PIN_EDGE:  rd_mux[NPIN-1:0] = pin_edge;
            OFF_PIN_PEND:  rd_mux[NPIN-1:0] = pin_pend;
            OFF_SRC_EN:    rd_mux[NSRC-1:0] = src_en;
            OFF_SRC_PEND:  rd_mux[NSRC-1:0] = src_pend;
            OFF_T0_CMP_LO: rd_mux = t_cmp[0][31:0];
            OFF_T0_CMP_HI: rd_mux[TMR_W-33:0] = t_cmp[0][TMR_W-1:32];
            OFF_T1_CMP_LO: rd_mux = t_cmp[1][31:0];
            OFF_T1_CMP_HI: rd_mux[TMR_W-33:0] = t_cmp[1][TMR_W-1:32];
            OFF_PC_CMP:    rd_mux = {pc_cmp[1], pc_cmp[0]};
            OFF_PC_CNT:    rd_mux = {pc_cnt[1], pc_cnt[0]};
            OFF_T0_CNT_LO: rd_mux = t_cnt[0][31:0];
            default: ;
        endcase
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_ACTIVE: begin
                if (deep_req) next_state = ST_DEEP;
                else if (sleep_req) next_state = ST_SLEEP;
                else if (doze_req) next_state = ST_DOZE;
            end
            ST_DOZE:       if (irq_i) next_state = ST_ACTIVE;
            ST_SLEEP:      if (any_wake) next_state = ST_CHK_SUPPLY;
            ST_DEEP:       if (deep_wake) next_state = ST_CHK_SUPPLY;
            ST_CHK_SUPPLY: if (sup_s) next_state = ST_HSRC;
            ST_HSRC:       if (hsrc_s) next_state = ST_PWR_ON;
            ST_PWR_ON:     if (settle_cnt == SETTLE_W'(PWR_SETTLE_CYC - 1)) next_state = ST_RELEASE;
            ST_RELEASE:    next_state = ST_ACTIVE;
        endcase
        if (hard) next_state = ST_CHK_SUPPLY;
    end

    // reset enters the same path as a power-up
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            state <= ST_CHK_SUPPLY;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            settle_cnt <= '0;
        end else if (state == ST_PWR_ON) begin
            settle_cnt <= settle_cnt + SETTLE_W'(1);
        end else begin
            settle_cnt <= '0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            soft_clr <= 1'b0;
            cause    <= CAUSE_POWERUP;
        end else begin
            soft_clr <= hard | (state == ST_DEEP && next_state == ST_CHK_SUPPLY);
            if (hard) begin
                cause <= ext_s ? CAUSE_EXTRST : CAUSE_POWERUP;
            end else if (state == ST_SLEEP && next_state == ST_CHK_SUPPLY) begin
                cause <= CAUSE_WAKE;
            end else if (state == ST_DEEP && next_state == ST_CHK_SUPPLY) begin
                cause <= CAUSE_POWERUP;
            end
        end
    end

    logic nx_run, nx_cpu, nx_low;
    assign nx_run = next_state == ST_ACTIVE || next_state == ST_DOZE;
    assign nx_cpu = nx_run || next_state == ST_PWR_ON || next_state == ST_RELEASE;
    assign nx_low = next_state == ST_SLEEP || next_state == ST_DEEP;

    // outputs track the state they belong to, one flop each
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            pwr_o         <= '0;
            pwr_o.aon     <= 1'b1;
            cpu_halt_o    <= 1'b0;
            cpu_reset_n_o <= 1'b0;
        end else begin
            pwr_o.digital <= nx_cpu;
            pwr_o.ram     <= nx_cpu || (next_state == ST_SLEEP
                              && (wr_ctrl ? hwdata_i[CTRL_RAM_RET] : cfg.ram_ret));
            pwr_o.radio   <= nx_run && radio_req_i;
            pwr_o.aon     <= 1'b1;
            pwr_o.timers  <= next_state != ST_DEEP && !(next_state == ST_SLEEP && !cfg.tmr_keep);
            pwr_o.osc32k  <= next_state != ST_DEEP && !(next_state == ST_SLEEP && !cfg.osc_keep);
            pwr_o.hsrc    <= !nx_low && next_state != ST_CHK_SUPPLY;
            cpu_halt_o    <= next_state == ST_DOZE;
            cpu_reset_n_o <= nx_run;
        end
    end

    // pins follow the core only while it runs
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            pin_out_o    <= PIN_RST;
            pin_oe_o     <= PIN_RST;
            pin_pullup_o <= PIN_RST;
        end else if (nx_run && (state == ST_ACTIVE || state == ST_DOZE)) begin
            pin_out_o    <= core_pin_out_i;
            pin_oe_o     <= core_pin_oe_i;
            pin_pullup_o <= core_pullup_i;
        end
    end

    chk_sleep_dig: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        state == ST_SLEEP |-> !pwr_o.digital) else $error("digital powered in sleep");
    chk_ram_retain: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        state == ST_SLEEP |-> pwr_o.ram == cfg.ram_ret) else $error("ram power mismatch");
    chk_radio_off: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (state == ST_SLEEP || state == ST_DEEP) |-> !pwr_o.radio) else $error("radio on while asleep");
    chk_aon_on: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        $past(resetn_i) |-> pwr_o.aon) else $error("always-on dropped");
    chk_doze_exit: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        state == ST_DOZE && irq_i && !hard |=> state == ST_ACTIVE && !cpu_halt_o) else $error("doze not ended");
    chk_pin_hold: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        state == ST_SLEEP && $past(state) == ST_SLEEP |-> $stable(pin_out_o) && $stable(pin_oe_o))
        else $error("pins moved in sleep");
    chk_osc_restart: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        state == ST_SLEEP && any_wake && !hard |=> pwr_o.osc32k) else $error("oscillator not restarted");
    chk_wake_gate: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        state == ST_SLEEP && !any_wake && !hard |=> state == ST_SLEEP) else $error("spurious wake");
    chk_settle_hold: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        $rose(pwr_o.digital) |-> !cpu_reset_n_o [*8]) else $error("reset released too early");
    chk_cause_wake: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        state == ST_SLEEP && any_wake && !hard |=> cause == CAUSE_WAKE) else $error("wake cause missing");
    chk_deep_domains: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        state == ST_DEEP |-> !pwr_o.osc32k && !pwr_o.ram && !pwr_o.timers) else $error("deep domain on");
    chk_deep_stay: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        state == ST_DEEP && !deep_wake && !hard |=> state == ST_DEEP) else $error("bad deep exit");

    cov_doze_trip: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
        state == ST_DOZE ##1 state == ST_ACTIVE);
    cov_sleep_wake: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
        state == ST_SLEEP ##1 state == ST_CHK_SUPPLY);
    cov_rewake: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
        state == ST_ACTIVE && sleep_req ##1 state == ST_SLEEP ##1 state == ST_CHK_SUPPLY);
    cov_deep_exit: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
        state == ST_DEEP ##1 state == ST_CHK_SUPPLY);
endmodule : pmwc_top
`default_nettype wire

// File: rtl/pmwc_wake_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pmwc_wake_timer (
    // clock and reset
    input  wire logic                       core_clk_i,
    input  wire logic                       resetn_i,
    // count control
    input  wire logic                       tick_i,
    input  wire logic [pmwc_pkg::TMR_W-1:0] cmp_i,
    // state
    output logic      [pmwc_pkg::TMR_W-1:0] cnt_o,
    output logic                            event_o
);
    import pmwc_pkg::*;

    // free running: keeps counting past its match
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            cnt_o <= '0;
        end else if (tick_i) begin
            cnt_o <= cnt_o + TMR_W'(1);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            event_o <= 1'b0;
        end else begin
            event_o <= tick_i && (cnt_o + TMR_W'(1) == cmp_i);
        end
    end
endmodule : pmwc_wake_timer
`default_nettype wire
